// File: shared/ccuip_params.svh
`ifndef CCUIP_PARAMS_SVH
`define CCUIP_PARAMS_SVH

// special function register addresses
`define CCUIP_ADDR_ENABLE   8'hC9
`define CCUIP_ADDR_SOURCE   8'hDE
`define CCUIP_ADDR_FLAGS    8'hE9

// flag and enable bit positions, same layout in both registers
`define CCUIP_BIT_CAP_A     0
`define CCUIP_BIT_CAP_B     1
`define CCUIP_BIT_RSVD      2
`define CCUIP_BIT_CMP_A     3
`define CCUIP_BIT_CMP_B     4
`define CCUIP_BIT_CMP_C     5
`define CCUIP_BIT_CMP_D     6
`define CCUIP_BIT_OVF       7

// writable bits: reserved bit 2 never stores
`define CCUIP_IMPL_MASK     8'hFB

// reset values
`define CCUIP_RST_FLAGS     8'h00
`define CCUIP_RST_ENABLE    8'h00
`define CCUIP_RST_CODE      3'h0
`define CCUIP_RST_RDATA     8'h00

// encoded source values
`define CCUIP_CODE_NONE     3'h0
`define CCUIP_CODE_CMP_D    3'h1
`define CCUIP_CODE_CMP_C    3'h2
`define CCUIP_CODE_CMP_B    3'h3
`define CCUIP_CODE_CMP_A    3'h4
`define CCUIP_CODE_CAP_B    3'h5
`define CCUIP_CODE_CAP_A    3'h6
`define CCUIP_CODE_OVF      3'h7

`endif

// File: shared/ccuip_pkg.sv
`include "ccuip_params.svh"

package ccuip_pkg;

    typedef enum logic [2:0] {
        CCUIP_SRC_NONE  = `CCUIP_CODE_NONE,
        CCUIP_SRC_CMP_D = `CCUIP_CODE_CMP_D,
        CCUIP_SRC_CMP_C = `CCUIP_CODE_CMP_C,
        CCUIP_SRC_CMP_B = `CCUIP_CODE_CMP_B,
        CCUIP_SRC_CMP_A = `CCUIP_CODE_CMP_A,
        CCUIP_SRC_CAP_B = `CCUIP_CODE_CAP_B,
        CCUIP_SRC_CAP_A = `CCUIP_CODE_CAP_A,
        CCUIP_SRC_OVF   = `CCUIP_CODE_OVF
    } ccuip_code_t;

    typedef logic [7:0] ccuip_byte_t;

endpackage : ccuip_pkg

// File: rtl/ccuip_sync.sv
`timescale 1ns/1ps

// three-stage synchroniser with rising-edge pulse on agreed level
module ccuip_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // asynchronous event levels
    input  wire logic [WIDTH-1:0] asyncIn,
    // one-cycle pulses in ref_clk domain
    output logic      [WIDTH-1:0] risePulse
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    // level only moves where stages two and three agree
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                level_nxt[i] = s3_r[i];
            end
        end
    end

    assign risePulse = level_nxt & ~level_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            level_r <= '0;
        end else begin
            s1_r    <= asyncIn;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

endmodule : ccuip_sync

// File: rtl/ccuip_prioritizer.sv
`timescale 1ns/1ps
`include "ccuip_params.svh"

module ccuip_prioritizer
    import ccuip_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // special function register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrWr,
    input  wire logic       sfrRd,
    output logic      [7:0] sfrRdData,
    // timer-domain event levels
    input  wire logic       overflowEvt,
    input  wire logic [1:0] captureEvt,
    input  wire logic [3:0] compareEvt,
    // compare channel enables from the unit configuration
    input  wire logic [3:0] compareChanEn,
    // processor-level enables
    input  wire logic       global_irq_enable,
    input  wire logic       unit_irq_enable,
    // shared request toward the processor
    output logic            irqReq,
    output logic [2:0]      encoded_source
);

    ccuip_byte_t flag_register_r;
    ccuip_byte_t flag_register_nxt;
    ccuip_byte_t enable_register_r;
    ccuip_byte_t enable_register_nxt;
    ccuip_code_t code_r;
    ccuip_code_t code_nxt;
    logic        irq_r;
    logic        irq_nxt;
    ccuip_byte_t rdData_r;
    ccuip_byte_t rdData_nxt;

    logic [6:0]  evtPulse;
    ccuip_byte_t setVec;
    ccuip_byte_t activeVec;
    logic        flagWrite;
    logic        enableWrite;

    // event inputs may run off the timer PLL, so all cross here
    ccuip_sync #(
        .WIDTH (7)
    ) u_evt_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .asyncIn   ({overflowEvt, compareEvt, captureEvt}),
        .risePulse (evtPulse)
    );

    assign flagWrite   = sfrWr && (sfrAddr == `CCUIP_ADDR_FLAGS);
    assign enableWrite = sfrWr && (sfrAddr == `CCUIP_ADDR_ENABLE);

    // hardware set requests, laid out as the flag register
    always_comb begin
        setVec = '0;
        setVec[`CCUIP_BIT_CAP_A] = evtPulse[0];
        setVec[`CCUIP_BIT_CAP_B] = evtPulse[1];
        setVec[`CCUIP_BIT_CMP_A] = evtPulse[2] && compareChanEn[0];
        setVec[`CCUIP_BIT_CMP_B] = evtPulse[3] && compareChanEn[1];
        setVec[`CCUIP_BIT_CMP_C] = evtPulse[4] && compareChanEn[2];
        setVec[`CCUIP_BIT_CMP_D] = evtPulse[5] && compareChanEn[3];
        setVec[`CCUIP_BIT_OVF]   = evtPulse[6];
    end

    // fixed-priority encoder over gated flags
    function automatic ccuip_code_t encode(input ccuip_byte_t act);
        ccuip_code_t c;
        c = CCUIP_SRC_NONE;
        if (act[`CCUIP_BIT_OVF]) begin
            c = CCUIP_SRC_OVF;
        end else if (act[`CCUIP_BIT_CAP_A]) begin
            c = CCUIP_SRC_CAP_A;
        end else if (act[`CCUIP_BIT_CAP_B]) begin
            c = CCUIP_SRC_CAP_B;
        end else if (act[`CCUIP_BIT_CMP_A]) begin
            c = CCUIP_SRC_CMP_A;
        end else if (act[`CCUIP_BIT_CMP_B]) begin
            c = CCUIP_SRC_CMP_B;
        end else if (act[`CCUIP_BIT_CMP_C]) begin
            c = CCUIP_SRC_CMP_C;
        end else if (act[`CCUIP_BIT_CMP_D]) begin
            c = CCUIP_SRC_CMP_D;
        end
        return c;
    endfunction : encode

    assign activeVec = flag_register_r & enable_register_r;

    // register state
    always_comb begin
        flag_register_nxt   = flag_register_r;
        enable_register_nxt = enable_register_r;
        // writing one leaves a flag alone; software cannot set flags
        if (flagWrite) begin
            flag_register_nxt = flag_register_r & sfrWrData;
        end
        // set merged last so a racing clear never eats an event
        flag_register_nxt = (flag_register_nxt | setVec) & `CCUIP_IMPL_MASK;
        if (enableWrite) begin
            enable_register_nxt = sfrWrData & `CCUIP_IMPL_MASK;
        end
        // code and request track the next flag state, so both move together
        code_nxt = encode(flag_register_nxt & enable_register_nxt);
        irq_nxt  = global_irq_enable && unit_irq_enable
                   && (code_nxt != CCUIP_SRC_NONE);
        rdData_nxt = rdData_r;
        if (sfrRd) begin
            case (sfrAddr)
                `CCUIP_ADDR_FLAGS:  rdData_nxt = flag_register_r;
                `CCUIP_ADDR_ENABLE: rdData_nxt = enable_register_r;
                `CCUIP_ADDR_SOURCE: rdData_nxt = {5'h00, code_r};
                default:            rdData_nxt = `CCUIP_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_register_r   <= `CCUIP_RST_FLAGS;
            enable_register_r <= `CCUIP_RST_ENABLE;
            code_r            <= CCUIP_SRC_NONE;
            irq_r             <= 1'h0;
            rdData_r          <= `CCUIP_RST_RDATA;
        end else begin
            flag_register_r   <= flag_register_nxt;
            enable_register_r <= enable_register_nxt;
            code_r            <= code_nxt;
            irq_r             <= irq_nxt;
            rdData_r          <= rdData_nxt;
        end
    end

    assign sfrRdData      = rdData_r;
    assign irqReq         = irq_r;
    assign encoded_source = code_r;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // level must read low long enough for the synchroniser to drop
    // the previous event, else no fresh edge is seen
    sequence s_ovf_rise;
        !overflowEvt [*3] ##1 overflowEvt [*4];
    endsequence

    // any set bit meeting a zero written to the same flag
    sequence s_set_during_clear;
        flagWrite && ((~sfrWrData & setVec) != 8'h00);
    endsequence

    // a flag write in flight may legally clear the flag again
    a_ovf_sync_set: assert property (
        disable iff (sys_rst || flagWrite)
        s_ovf_rise |-> ##[0:2] flag_register_r[`CCUIP_BIT_OVF])
        else $error("overflow event not flagged in time");

    a_set_beats_clear: assert property (
        s_set_during_clear
        |=> (flag_register_r & $past(setVec)) == $past(setVec))
        else $error("hardware set lost to software clear");

    a_clear_only_addr: assert property (
        flagWrite && (setVec == 8'h00)
        |=> flag_register_r == ($past(flag_register_r) & $past(sfrWrData)))
        else $error("flag write disturbed other flags");

    a_ovf_top_prio: assert property (
        activeVec[`CCUIP_BIT_OVF] && $stable(activeVec) |-> code_r == CCUIP_SRC_OVF)
        else $error("overflow not given top priority");

    a_cmp_d_code: assert property (
        (activeVec == 8'h40) && $stable(activeVec) |-> code_r == CCUIP_SRC_CMP_D)
        else $error("compare D alone gives wrong code");

    a_cap_sticky: assert property (
        flag_register_r[`CCUIP_BIT_CAP_A] && !flagWrite
        |=> flag_register_r[`CCUIP_BIT_CAP_A] [*1])
        else $error("capture A flag dropped without a clear");

    a_cmp_chan_gate: assert property (
        $rose(flag_register_r[`CCUIP_BIT_CMP_A]) |-> $past(compareChanEn[0]))
        else $error("compare A flag set with channel disabled");

    a_irq_enables: assert property (
        irqReq |-> $past(global_irq_enable) && $past(unit_irq_enable)
                   && (code_r != CCUIP_SRC_NONE))
        else $error("request without all enables");

    a_irq_follows: assert property (
        global_irq_enable && unit_irq_enable && (code_nxt != CCUIP_SRC_NONE)
        |=> irqReq && (encoded_source != CCUIP_SRC_NONE))
        else $error("request not raised for pending source");

    a_rsvd_zero: assert property (
        enableWrite |=> !enable_register_r[`CCUIP_BIT_RSVD] && !flag_register_r[`CCUIP_BIT_RSVD])
        else $error("reserved bit stored");

endmodule : ccuip_prioritizer

// File: tb/ccuip_sw_model.sv
`timescale 1ns/1ps
`include "ccuip_params.svh"

// service software: single owner of the register bus
module ccuip_sw_model (
    // register bus toward the block
    input  wire logic       ref_clk,
    input  wire logic [7:0] sfrRdData,
    output logic      [7:0] sfrAddr,
    output logic      [7:0] sfrWrData,
    output logic            sfrWr,
    output logic            sfrRd
);
    initial begin
        sfrAddr   = 8'h00;
        sfrWrData = 8'h00;
        sfrWr     = 1'b0;
        sfrRd     = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfrAddr   <= a;
        sfrWrData <= d & `CCUIP_IMPL_MASK;
        sfrWr     <= 1'b1;
        @(posedge ref_clk);
        sfrWr     <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrRd   <= 1'b1;
        @(posedge ref_clk);
        sfrRd   <= 1'b0;
        #1 d = sfrRdData;
    endtask : rd

    // bounded so a stuck code cannot hang the run
    task automatic service();
        logic [7:0] c;
        int         pos [8];
        pos = '{0, 6, 5, 4, 3, 1, 0, 7};
        rd(`CCUIP_ADDR_SOURCE, c);
        for (int i = 0; i < 8 && c !== 8'h00; i++) begin
            wr(`CCUIP_ADDR_FLAGS, ~(8'h01 << pos[c[2:0]]));
            rd(`CCUIP_ADDR_SOURCE, c);
        end
    endtask : service
endmodule : ccuip_sw_model

// File: tb/tb_ccu_interrupt_prioritizer.sv
`timescale 1ns/1ps
`include "ccuip_params.svh"

module tb_ccu_interrupt_prioritizer;
    logic       ref_clk, sys_rst, overflowEvt, global_irq_enable, unit_irq_enable, irqReq;
    logic [1:0] captureEvt;
    logic [3:0] compareEvt, compareChanEn;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, expFlags, expEn, got;
    logic       sfrWr, sfrRd;
    logic [2:0] encoded_source;
    logic [31:0] r;
    int         num_errors, n_tests, seed;

    ccuip_prioritizer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData),
        .overflowEvt(overflowEvt), .captureEvt(captureEvt), .compareEvt(compareEvt),
        .compareChanEn(compareChanEn), .global_irq_enable(global_irq_enable),
        .unit_irq_enable(unit_irq_enable), .irqReq(irqReq), .encoded_source(encoded_source));
    ccuip_sw_model i_sw (.ref_clk(ref_clk), .sfrRdData(sfrRdData), .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd));

    function automatic logic [7:0] exp_code(input logic [7:0] p);
        if (p[7]) return 8'h07;
        if (p[0]) return 8'h06;
        if (p[1]) return 8'h05;
        if (p[3]) return 8'h04;
        if (p[4]) return 8'h03;
        if (p[5]) return 8'h02;
        if (p[6]) return 8'h01;
        return 8'h00;
    endfunction : exp_code

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic check_state();
        logic [7:0] c;
        c = exp_code(expFlags & expEn);
        i_sw.rd(`CCUIP_ADDR_FLAGS, got);
        check(got, expFlags);
        i_sw.rd(`CCUIP_ADDR_SOURCE, got);
        check(got, c);
        check({5'h00, encoded_source}, c);
        check({7'h00, irqReq}, {7'h00, global_irq_enable & unit_irq_enable & (c != 0)});
    endtask : check_state

    // levels held 4 cycles high and low, longer than the synchroniser needs
    task automatic fire(input logic [7:0] ev);
        @(posedge ref_clk);
        overflowEvt <= ev[7];
        captureEvt  <= ev[1:0];
        compareEvt  <= ev[6:3];
        expFlags    = expFlags | (ev & {1'b1, compareChanEn, 3'h3});
        repeat (4) @(posedge ref_clk);
        overflowEvt <= 1'b0;
        captureEvt  <= 2'h0;
        compareEvt  <= 4'h0;
        repeat (4) @(posedge ref_clk);
    endtask : fire

    task automatic wrap_up();
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        seed = 12;
        {sys_rst, overflowEvt, captureEvt, compareEvt} = 8'h80;
        {compareChanEn, global_irq_enable, unit_irq_enable} = 6'h00;
        {expFlags, expEn} = 16'h0000;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check_state();
        i_sw.rd(`CCUIP_ADDR_ENABLE, got);
        check(got, `CCUIP_RST_ENABLE);
        i_sw.rd(8'h00, got);
        check(got, 8'h00);
        expEn = 8'hFB;
        i_sw.wr(`CCUIP_ADDR_ENABLE, expEn);
        global_irq_enable <= 1'b1;
        unit_irq_enable   <= 1'b1;
        // zero write lands in the very cycle the overflow sets its flag
        @(posedge ref_clk);
        overflowEvt <= 1'b1;
        repeat (2) @(posedge ref_clk);
        i_sw.wr(`CCUIP_ADDR_FLAGS, 8'h7F);
        overflowEvt <= 1'b0;
        expFlags = 8'h80;
        repeat (4) @(posedge ref_clk);
        check_state();
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            expEn = r[7:0] & `CCUIP_IMPL_MASK;
            i_sw.wr(`CCUIP_ADDR_ENABLE, expEn);
            global_irq_enable <= r[8];
            unit_irq_enable   <= r[9] | r[10];
            compareChanEn     <= r[14:11];
            fire(r[23:16]);
            i_sw.rd(`CCUIP_ADDR_ENABLE, got);
            check(got, expEn);
            check_state();
            r[2:0] = (r[26:24] == 3'h2) ? 3'h7 : r[26:24];
            i_sw.wr(`CCUIP_ADDR_FLAGS, ~(8'h01 << r[2:0]));
            expFlags[r[2:0]] = 1'b0;
            check_state();
            if (i % 3 == 2) begin
                i_sw.service();
                expFlags = expFlags & ~expEn;
                check_state();
            end
        end
        wrap_up();
    end
endmodule : tb_ccu_interrupt_prioritizer
